// file: capture_pkg.sv
package capture_pkg;
  // Link word width and output pair width
  localparam int DATA_W      = 8;
  localparam int PAIR_W      = 2 * DATA_W;
  // Resynchronization tick: one mclk cycle in every RESYNC_DIV
  localparam int RESYNC_DIV  = 4;
  localparam int FIFO_DEPTH  = 4;
  // Reset values of the postamble flop and the data words
  localparam logic POST_RESET = 1'b1;
  localparam logic [DATA_W-1:0] WORD_RESET = 8'h00;
  // Clock periods in ns, kept for reference by the counts
  localparam int MCLK_PERIOD_NS = 20;
  localparam int LINK_PERIOD_NS = 160;
endpackage

// file: ddr_read_model.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side of a read: strobe edges sit in the middle of each data half
module ddr_read_model (
  input  wire logic       go,
  input  wire logic [3:0] beats,
  input  wire logic       noise,
  input  wire logic [7:0] base,
  output logic            dqs,
  output logic      [7:0] dq,
  output logic            last_beat,
  output logic            busy
);
  initial begin
    dqs = 1'b0;
    dq = 8'hA5;
    last_beat = 1'b0;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    dqs = 1'b0;
    #40;
    for (int k = 0; k < int'(beats); k++) begin
      dq = base + 8'(2 * k);
      #40;
      dqs = 1'b1;
      last_beat = (k == int'(beats) - 1);
      #40;
      dq = base + 8'(2 * k + 1);
      #40;
      dqs = 1'b0;
      #40;
    end
    // Released lines sit mid-rail, so a floating strobe may read as edges
    dq = ~dq;
    last_beat = 1'b0;
    for (int g = 0; g < 6; g++) begin
      #100;
      if (noise) dqs = ~dqs;
    end
    busy = 1'b0;
  end
endmodule
`default_nettype wire

// file: dqs_read_capture_postamble.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - high-phase word taken on strobe rise, re-taken on strobe fall.
// - high and low words appear together only after the strobe falling edge.
// - low word captured while previous high word passes through another register.
// - both words move together into the system domain on the resync tick.
// - capture registers are disabled after the postamble so noise latches nothing.
// - each strobe input has its own single-flop postamble circuit.
// - the postamble flop is clocked by mclk and moves only on a shifted-strobe fall, the preset or rst_n.
// - postamble flop data is zero; first strobe fall after preset release drives it low.
// - on that falling edge the active-low enable output turns capture off.

module pair_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("pair_fifo: depth must be at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count != DEPTH_C);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_count  = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; out_valid masks stale words
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module dqs_read_capture_postamble
  import capture_pkg::*;
#(
  parameter int W   = capture_pkg::DATA_W,
  parameter int DIV = capture_pkg::RESYNC_DIV,
  parameter int DEP = capture_pkg::FIFO_DEPTH
) (
  input  wire logic           mclk,
  input  wire logic           rst_n,
  input  wire logic           dqs_shifted,
  input  wire logic [W-1:0]   dq,
  input  wire logic           postamble_preset,
  output logic                capture_enable_low,
  output logic                overrun,
  output logic      [2*W-1:0] rd_data,
  output logic                rd_valid,
  input  wire logic           rd_ready
);
  import capture_pkg::*;
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  initial begin
    if (W < 1 || DIV < 2) $error("dqs_read_capture_postamble: bad width or divider");
  end

  // Strobe, data and preset arrive from outside mclk; two flops each.
  // Data and strobe share the same depth so their alignment is kept.
  logic         dqs_meta;
  logic         dqs_sync;
  logic         dqs_prev;
  logic [W-1:0] dq_meta;
  logic [W-1:0] dq_sync;
  logic         pre_meta;
  logic         pre_sync;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dqs_meta <= 1'b0;
      dqs_sync <= 1'b0;
      dqs_prev <= 1'b0;
      dq_meta  <= '0;
      dq_sync  <= '0;
      pre_meta <= 1'b1;
      pre_sync <= 1'b1;
    end else begin
      dqs_meta <= dqs_shifted;
      dqs_sync <= dqs_meta;
      dqs_prev <= dqs_sync;
      dq_meta  <= dq;
      dq_sync  <= dq_meta;
      pre_meta <= postamble_preset;
      pre_sync <= pre_meta;
    end
  end

  logic rise;
  logic fall;
  assign rise = dqs_sync & ~dqs_prev;
  assign fall = ~dqs_sync & dqs_prev;

  logic         post_q;
  logic [W-1:0] hi_first;
  logic [W-1:0] hi_word;
  logic [W-1:0] lo_word;
  logic         pair_pending;
  logic [CW-1:0] div_cnt;
  logic         next_post_q;
  logic [W-1:0] next_hi_first;
  logic [W-1:0] next_hi_word;
  logic [W-1:0] next_lo_word;
  logic         next_pair_pending;
  logic [CW-1:0] next_div_cnt;
  logic         next_overrun;
  logic         tick;
  logic         push;
  logic         fifo_ready;
  logic         take_fall;

  assign tick      = (div_cnt == CW'(DIV - 1));
  assign push      = tick & pair_pending & fifo_ready;
  assign take_fall = fall & post_q;
  assign capture_enable_low = ~post_q;

  always_comb begin
    next_div_cnt      = tick ? '0 : div_cnt + 1'b1;
    next_post_q       = post_q;
    next_hi_first     = hi_first;
    next_hi_word      = hi_word;
    next_lo_word      = lo_word;
    next_pair_pending = pair_pending;
    // A word left waiting on a full FIFO is overwritten by the next pair
    next_overrun      = take_fall & pair_pending & ~push;
    if (pre_sync) begin
      next_post_q = POST_RESET;
    end else if (fall) begin
      next_post_q = 1'b0;
    end
    if (rise && post_q) begin
      next_hi_first = dq_sync;
    end
    if (push) begin
      next_pair_pending = 1'b0;
    end
    // The final fall still captures; the flop only drops after it
    if (take_fall) begin
      next_hi_word      = hi_first;
      next_lo_word      = dq_sync;
      next_pair_pending = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      post_q       <= POST_RESET;
      hi_first     <= WORD_RESET;
      hi_word      <= WORD_RESET;
      lo_word      <= WORD_RESET;
      pair_pending <= 1'b0;
      div_cnt      <= '0;
      overrun      <= 1'b0;
    end else begin
      post_q       <= next_post_q;
      hi_first     <= next_hi_first;
      hi_word      <= next_hi_word;
      lo_word      <= next_lo_word;
      pair_pending <= next_pair_pending;
      div_cnt      <= next_div_cnt;
      overrun      <= next_overrun;
    end
  end

  pair_fifo #(
    .WIDTH (2 * W),
    .DEPTH (DEP)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   ({hi_word, lo_word}),
    .in_valid  (tick & pair_pending),
    .in_ready  (fifo_ready),
    .out_data  (rd_data),
    .out_valid (rd_valid),
    .out_ready (rd_ready)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_high_on_rise: assert property (rise && post_q |=> hi_first == $past(dq_sync))
    else $error("high word not taken on strobe rise");
  a_pair_on_fall: assert property (take_fall |=> pair_pending && lo_word == $past(dq_sync))
    else $error("pair not formed on strobe fall");
  a_pending_cause: assert property ($rose(pair_pending) |-> $past(fall))
    else $error("pair appeared without a strobe fall");
  a_high_passed: assert property (take_fall |=> hi_word == $past(hi_first))
    else $error("high word not passed through on fall");
  a_resync_tick: assert property ($fell(pair_pending) |-> $past(tick) && $past(fifo_ready))
    else $error("pair left outside a resync tick");
  a_capture_off: assert property (!post_q && !pre_sync |=> $stable(hi_first) && $stable(lo_word))
    else $error("capture changed while disabled");
  a_preset_holds: assert property (pre_sync |=> post_q)
    else $error("preset did not set postamble flop");
  a_strobe_only: assert property (!fall && !pre_sync |=> $stable(post_q))
    else $error("postamble flop moved without strobe edge");
  a_zero_data: assert property (fall && !pre_sync |=> !post_q)
    else $error("postamble flop not cleared by strobe fall");
  a_enable_drop: assert property ($rose(capture_enable_low) |-> $past(fall) && !$past(pre_sync))
    else $error("enable output changed off a postamble fall");
endmodule
`default_nettype wire

// file: dqs_read_capture_postamble_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dqs_read_capture_postamble_tb;
  import capture_pkg::*;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              postamble_preset = 1'b1;
  logic              rd_ready = 1'b0;
  logic              go = 1'b0;
  logic              noise = 1'b0;
  logic [3:0]        beats = 4'h0;
  logic [7:0]        base = 8'h00;
  logic              dqs_shifted, last_beat, busy, capture_enable_low, overrun, rd_valid;
  logic [DATA_W-1:0] dq;
  logic [PAIR_W-1:0] rd_data;
  logic [PAIR_W-1:0] got[$];
  int                errors = 0;
  int                checks_done = 0;
  int                lost = 0;

  always #10 mclk = ~mclk;
  ddr_read_model mem_u (.go(go), .beats(beats), .noise(noise), .base(base), .dqs(dqs_shifted), .dq(dq),
    .last_beat(last_beat), .busy(busy));
  dqs_read_capture_postamble dut_u (.mclk(mclk), .rst_n(rst_n), .dqs_shifted(dqs_shifted), .dq(dq),
    .postamble_preset(postamble_preset), .capture_enable_low(capture_enable_low), .overrun(overrun),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
  always @(posedge mclk) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
    if (overrun === 1'b1) lost++;
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t ns: %s got %0h expected %0h", $time, m, g, e);
    end
  endtask
  task automatic expect_pairs(input logic [7:0] b, input int ks[$]);
    check(got.size(), ks.size(), "pair count");
    foreach (ks[i]) begin
      if (i < got.size()) check(got[i], {b + 8'(2 * ks[i]), b + 8'(2 * ks[i] + 1)}, "pair order");
    end
    got.delete();
  endtask
  // Controller side: arm before the preamble, drop the preset in the last high phase
  task automatic burst(input logic [3:0] n, input logic nz, input logic [7:0] b);
    @(posedge mclk) #2 postamble_preset = 1'b1;
    beats = n;
    noise = nz;
    base = b;
    repeat (4) @(posedge mclk);
    #2 check(capture_enable_low, 1'b0, "armed enable");
    go = 1'b1;
    wait (last_beat === 1'b1);
    @(posedge mclk) #2 postamble_preset = 1'b0;
    go = 1'b0;
    while (busy !== 1'b0) @(posedge mclk);
    #2 check(capture_enable_low, 1'b1, "enable after postamble");
  endtask
  task automatic t_plain;
    rd_ready = 1'b1;
    burst(4'd3, 1'b0, 8'h10);
    repeat (10) @(posedge mclk);
    expect_pairs(8'h10, '{0, 1, 2});
    $display("test plain burst done");
  endtask
  task automatic t_noise;
    burst(4'd2, 1'b1, 8'h40);
    repeat (10) @(posedge mclk);
    expect_pairs(8'h40, '{0, 1});
    $display("test strobe noise done");
  endtask
  task automatic t_full;
    @(posedge mclk) #2 rd_ready = 1'b0;
    burst(4'd6, 1'b0, 8'h80);
    check(lost, 1, "overrun pulses");
    check(rd_valid, 1'b1, "fifo holds data");
    @(posedge mclk) #2 rd_ready = 1'b1;
    repeat (12) @(posedge mclk);
    #2 check(rd_valid, 1'b0, "fifo drained");
    expect_pairs(8'h80, '{0, 1, 2, 3, 5});
    $display("test fifo fill done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #30000;
    errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge mclk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    t_plain();
    t_noise();
    t_full();
    tally_and_finish();
  end
endmodule
`default_nettype wire
